// file: logic/dual_timer_pkg.sv
package dual_timer_pkg;
  localparam int unsigned addr_w = 8;
  localparam int unsigned data_w = 8;
  // Register offsets
  localparam logic [7:0] off_irq_enable = 8'hE2;
  localparam logic [7:0] off_event = 8'hE3;
  localparam logic [7:0] off_a_value = 8'hE8;
  localparam logic [7:0] off_a_control = 8'hE9;
  localparam logic [7:0] off_a_snapshot = 8'hEA;
  localparam logic [7:0] off_a_snapshot_inv = 8'hEB;
  localparam logic [7:0] off_b_value = 8'hEC;
  localparam logic [7:0] off_b_control = 8'hED;
  // Control field positions
  localparam int unsigned bit_run = 7;
  localparam int unsigned bit_reload_inhibit = 6;
  localparam int unsigned bit_event_edge = 5;
  localparam int unsigned bit_snap_source = 4;
  localparam int unsigned bit_snap_edge = 3;
  localparam int unsigned bit_duty = 2;
  localparam int unsigned bit_clk_hi = 1;
  localparam int unsigned bit_clk_lo = 0;
  // Event and enable bit positions
  localparam int unsigned bit_evt_a = 3;
  localparam int unsigned bit_evt_b = 2;
  // Reset values
  localparam logic [7:0] value_reset = 8'hFF;
  localparam logic [7:0] zero_byte = 8'h00;
  localparam logic [7:0] snap_reset = 8'h00;
  // Prescaler terminal counts
  localparam logic [3:0] div4_mask = 4'h3;
  localparam logic [3:0] div16_mask = 4'hF;
  // Clock select encodings
  localparam logic [1:0] clk_div1 = 2'h0;
  localparam logic [1:0] clk_div4 = 2'h1;
  localparam logic [1:0] clk_div16 = 2'h2;
  localparam logic [1:0] clk_pin = 2'h3;
  // Duty phase states of the underflow output
  typedef enum logic [1:0] {
    phase_low = 2'b00,
    phase_high1 = 2'b01,
    phase_high2 = 2'b11
  } duty_phase_t;
endpackage

// file: logic/dual_timer_with_capture.sv
// Contract
// - Timer A is 8-bit, decrements per tick, underflows at clock over reload plus one.
// - Reading timer A value gives live count; writing sets reload value.
// - Capture trigger stores count in snapshot and its complement in second register.
// - Run bit 1 starts and preloads; 1 while running ignored; 0 stops.
// - Reload inhibit 1 disables auto reload at underflow; 0 reloads.
// - Event edge bit picks rising 0 or falling 1 of external clock.
// - Snapshot source 0 is infrared input when in input mode, 1 port1 pin1.
// - Snapshot edge bit picks rising 0 or falling 1 of capture source.
// - Underflow output duty 1:1 when bit 0; low one, high two when 1.
// - Timer A clock select: osc, osc/4, osc/16, port1 pin0 edges.
// - Timer B is 8-bit down-counter underflowing at clock over reload plus one.
// - Reading timer B value gives live count; writing sets reload value.
// - Timer B clock select 0 is oscillator, 1 is oscillator over 16.
// - Each underflow sets its own sticky event flag until software clears it.
// - Writing 0 to a timer bit of event clear clears that event.
// - Underflow interrupts only when its enable bit is 1; enables reset to 0.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_with_capture (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [dual_timer_pkg::addr_w-1:0] addr,
  input wire logic [dual_timer_pkg::data_w-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [dual_timer_pkg::data_w-1:0] rdata,
  input wire logic port1_pin0,
  input wire logic port1_pin1,
  input wire logic infrared_input,
  input wire logic infrared_input_mode,
  output logic underflow_out,
  output logic irq
);
  import dual_timer_pkg::*;

  function automatic logic edge_hit(input logic prev, input logic cur, input logic falling);
    edge_hit = falling ? (prev & ~cur) : (~prev & cur);
  endfunction

  // Two-stage synchronisers for the three pins, then one history stage
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_prev;
  wire [2:0] pin_raw = {infrared_input, port1_pin1, port1_pin0};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          // Pins idle high on their pull-ups, so no false rising edge follows reset
          pin_meta[gi] <= 1'b1;
          pin_sync[gi] <= 1'b1;
          pin_prev[gi] <= 1'b1;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
          pin_prev[gi] <= pin_sync[gi];
        end
      end
    end
  endgenerate

  // Registers
  logic [7:0] a_reload, a_count, a_ctl, a_snap, a_snap_inv;
  logic [7:0] b_reload, b_count, b_ctl;
  logic [7:0] irq_enable, event_status;
  logic [3:0] prescale;
  logic ir_mode_meta, ir_mode_sync;
  duty_phase_t phase;

  wire wr_a_value = wr && (addr == off_a_value);
  wire wr_a_ctl = wr && (addr == off_a_control);
  wire wr_b_value = wr && (addr == off_b_value);
  wire wr_b_ctl = wr && (addr == off_b_control);
  wire wr_enable = wr && (addr == off_irq_enable);
  wire wr_event = wr && (addr == off_event);

  // Run bit: rising write starts with preload, repeated 1 ignored
  wire a_start = wr_a_ctl && wdata[bit_run] && !a_ctl[bit_run];
  wire b_start = wr_b_ctl && wdata[bit_run] && !b_ctl[bit_run];

  // Tick generation
  wire [1:0] a_sel = {a_ctl[bit_clk_hi], a_ctl[bit_clk_lo]};
  wire pin0_edge = edge_hit(pin_prev[0], pin_sync[0], a_ctl[bit_event_edge]);
  wire tick4 = (prescale & div4_mask) == div4_mask;
  wire tick16 = prescale == div16_mask;
  wire a_tick_src = (a_sel == clk_div1) ? 1'b1 :
                    (a_sel == clk_div4) ? tick4 :
                    (a_sel == clk_div16) ? tick16 : pin0_edge;
  wire b_tick_src = b_ctl[bit_clk_lo] ? tick16 : 1'b1;
  wire a_tick = a_ctl[bit_run] && a_tick_src && !a_start;
  wire b_tick = b_ctl[bit_run] && b_tick_src && !b_start;
  wire a_under = a_tick && (a_count == zero_byte);
  wire b_under = b_tick && (b_count == zero_byte);

  // Capture trigger selection
  wire snap_src_now = a_ctl[bit_snap_source] ? pin_sync[1] : pin_sync[2];
  wire snap_src_old = a_ctl[bit_snap_source] ? pin_prev[1] : pin_prev[2];
  wire snap_gate = a_ctl[bit_snap_source] || ir_mode_sync;
  wire snap_hit = snap_gate && edge_hit(snap_src_old, snap_src_now, a_ctl[bit_snap_edge]);

  // Next counts
  wire [7:0] next_a_count = a_start ? a_reload :
                            !a_tick ? a_count :
                            (a_count != zero_byte) ? a_count - 8'h01 :
                            a_ctl[bit_reload_inhibit] ? a_count : a_reload;
  wire [7:0] next_b_count = b_start ? b_reload :
                            !b_tick ? b_count :
                            (b_count != zero_byte) ? b_count - 8'h01 :
                            b_ctl[bit_reload_inhibit] ? b_count : b_reload;
  wire a_halt = a_under && a_ctl[bit_reload_inhibit];
  wire b_halt = b_under && b_ctl[bit_reload_inhibit];

  // Event flags: set wins over clear
  wire [7:0] evt_set = ({7'h00, a_under} << bit_evt_a) | ({7'h00, b_under} << bit_evt_b);
  wire [7:0] evt_keep = wr_event ? (event_status & wdata) : event_status;
  wire [7:0] evt_mask = ({7'h00, 1'b1} << bit_evt_a) | ({7'h00, 1'b1} << bit_evt_b);
  wire [7:0] next_event = (evt_keep | evt_set) & evt_mask;
  wire next_irq = |(next_event & irq_enable);

  // Duty phase of the underflow output
  duty_phase_t next_phase;
  always_comb begin
    next_phase = phase;
    if (a_under) begin
      case (phase)
        phase_low: next_phase = phase_high1;
        phase_high1: next_phase = a_ctl[bit_duty] ? phase_high2 : phase_low;
        phase_high2: next_phase = phase_low;
        default: next_phase = phase_low;
      endcase
    end
  end

  // Read data
  wire [7:0] next_rdata = (addr == off_a_value) ? a_count :
                          (addr == off_a_snapshot) ? a_snap :
                          (addr == off_a_snapshot_inv) ? a_snap_inv :
                          (addr == off_b_value) ? b_count :
                          (addr == off_irq_enable) ? irq_enable :
                          (addr == off_event) ? event_status : zero_byte;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ir_mode_meta <= 1'b0;
      ir_mode_sync <= 1'b0;
    end else begin
      ir_mode_meta <= infrared_input_mode;
      ir_mode_sync <= ir_mode_meta;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prescale <= 4'h0;
    end else begin
      prescale <= prescale + 4'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      a_reload <= value_reset;
      a_count <= value_reset;
    end else begin
      if (wr_a_value) begin
        a_reload <= wdata;
      end
      a_count <= next_a_count;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      a_ctl <= zero_byte;
    end else if (wr_a_ctl) begin
      a_ctl <= wdata;
    end else if (a_halt) begin
      a_ctl[bit_run] <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      b_reload <= value_reset;
      b_count <= value_reset;
    end else begin
      if (wr_b_value) begin
        b_reload <= wdata;
      end
      b_count <= next_b_count;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      b_ctl <= zero_byte;
    end else if (wr_b_ctl) begin
      b_ctl <= wdata;
    end else if (b_halt) begin
      b_ctl[bit_run] <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      a_snap <= snap_reset;
      a_snap_inv <= ~snap_reset;
    end else if (snap_hit) begin
      a_snap <= a_count;
      a_snap_inv <= ~a_count;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_enable <= zero_byte;
      event_status <= zero_byte;
      irq <= 1'b0;
    end else begin
      if (wr_enable) begin
        irq_enable <= wdata & evt_mask;
      end
      event_status <= next_event;
      irq <= next_irq;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase <= phase_low;
      underflow_out <= 1'b0;
      rdata <= zero_byte;
    end else begin
      phase <= next_phase;
      underflow_out <= (next_phase != phase_low);
      rdata <= rd ? next_rdata : zero_byte;
    end
  end
endmodule
`default_nettype wire

// file: testbench/dual_timer_with_capture_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dual_timer_with_capture_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [dual_timer_pkg::addr_w-1:0] addr,
  input wire logic [dual_timer_pkg::data_w-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [dual_timer_pkg::data_w-1:0] rdata,
  input wire logic underflow_out,
  input wire logic irq
);
  import dual_timer_pkg::*;
  // Shadow of the enable bits, A then B
  logic [1:0] en;
  always_ff @(posedge mclk or posedge rst)
    if (rst) en <= 2'b00;
    else if (wr && addr == off_irq_enable) en <= {wdata[bit_evt_a], wdata[bit_evt_b]};
  property p_reset_quiet;
    @(posedge mclk) rst |-> rdata == 8'h00 && !irq && !underflow_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy in reset");
  property p_rdata_idle;
    @(posedge mclk) disable iff (rst) !rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
  property p_wo_zero;
    @(posedge mclk) disable iff (rst)
      rd && (addr == off_a_control || addr == off_b_control) |=> rdata == 8'h00;
  endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("control read not zero");
  property p_unmapped;
    @(posedge mclk) disable iff (rst) rd && addr < 8'hE2 |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_evt_bits;
    @(posedge mclk) disable iff (rst)
      rd && addr == off_event |=> rdata[7:4] == 4'h0 && rdata[1:0] == 2'b00;
  endproperty
  a_evt_bits: assert property (p_evt_bits) else $error("event spare bits set");
  property p_en_read;
    @(posedge mclk) disable iff (rst) rd && addr == off_irq_enable |=> rdata == {4'h0, en, 2'b00};
  endproperty
  a_en_read: assert property (p_en_read) else $error("enable readback wrong");
  property p_irq_masked;
    @(posedge mclk) disable iff (rst) en == 2'b00 && $past(en) == 2'b00 |-> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq while masked");
  property p_snap_pair;
    @(posedge mclk) disable iff (rst)
      rd && addr == off_a_snapshot_inv && $past(rd && addr == off_a_snapshot)
      |=> rdata == ~$past(rdata);
  endproperty
  a_snap_pair: assert property (p_snap_pair) else $error("snapshot pair mismatch");
endmodule
bind dual_timer_with_capture dual_timer_with_capture_properties i_props (.mclk(mclk), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .underflow_out(underflow_out),
  .irq(irq));
`default_nettype wire

// file: testbench/test_dual_timer_with_capture.sv
`timescale 1ns/1ps
`default_nettype none
module test_dual_timer_with_capture;
  import dual_timer_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic port1_pin0 = 1'b0;
  logic port1_pin1 = 1'b0;
  logic infrared_input = 1'b1;
  logic infrared_input_mode = 1'b1;
  logic underflow_out;
  logic irq;
  logic rd_q = 1'b0;
  logic [7:0] exp_q[$];
  logic [15:0] tbl[9] = '{16'hE8FF, 16'hEA00, 16'hEBFF, 16'hECFF, 16'hE200, 16'hE300,
    16'hE900, 16'hED00, 16'h0000};
  logic [7:0] cfg[4] = '{8'h80, 8'h81, 8'h82, 8'h84};
  int m[4] = '{1, 4, 16, 1};
  int err_total = 0;
  int samples_checked = 0;
  int seed = 32'h99628B61;
  int hi;
  int lo;
  logic [7:0] r;
  logic [7:0] v1;
  logic [7:0] v2;
  always #2.5 mclk = ~mclk;
  dual_timer_with_capture i_dual_timer_with_capture (.mclk(mclk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .port1_pin0(port1_pin0),
    .port1_pin1(port1_pin1), .infrared_input(infrared_input),
    .infrared_input_mode(infrared_input_mode), .underflow_out(underflow_out), .irq(irq));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Strobes stay up between back-to-back transfers; cyc drops them
  task automatic op(input bit w, input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    if (!w) exp_q.push_back(d);
    @(posedge mclk);
  endtask
  task automatic cyc(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask
  task automatic span(input logic lvl, output int n);
    n = 0;
    while (underflow_out === lvl && n < 3000) begin
      @(negedge mclk);
      n++;
    end
  endtask
  task automatic ichk(input logic e);
    @(negedge mclk);
    chk("irq", {15'h0, e}, {15'h0, irq});
    @(posedge mclk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge mclk) begin
    if (rd_q) chk("rdata", {8'h00, exp_q.pop_front()}, {8'h00, rdata});
    rd_q <= rd;
  end
  initial begin
    #100000;
    err_total++;
    wrap_up;
  end
  initial begin
    rst <= 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    cyc(1);
    foreach (tbl[i]) op(0, tbl[i][15:8], tbl[i][7:0]);
    cyc(2);
    $display("test reset done");
    r = {5'h00, 3'($random(seed))} + 8'h01;
    foreach (cfg[i]) begin
      op(1, off_a_value, r);
      op(1, off_a_control, cfg[i]);
      cyc(1);
      span(1, hi);
      span(0, hi);
      span(1, hi);
      span(0, lo);
      chk("high", 16'(m[i] * (r + 1) * (cfg[i][2] ? 2 : 1)), 16'(hi));
      chk("low", 16'(m[i] * (r + 1)), 16'(lo));
      op(1, off_a_control, 8'h00);
    end
    op(0, off_event, 8'h08);
    cyc(2);
    ichk(1'b0);
    op(1, off_irq_enable, 8'h08);
    cyc(3);
    ichk(1'b1);
    op(1, off_event, 8'h00);
    op(0, off_event, 8'h00);
    cyc(3);
    ichk(1'b0);
    op(1, off_b_value, 8'h03);
    op(1, off_b_control, 8'hC1);
    cyc(40);
    op(0, off_event, 8'h00);
    cyc(60);
    op(0, off_event, 8'h04);
    op(0, off_b_value, 8'h00);
    cyc(2);
    $display("test timers done");
    v1 = 8'($random(seed)) | 8'h01;
    v2 = v1 ^ 8'h5A;
    op(1, off_a_value, v1);
    op(1, off_a_control, 8'h93);
    port1_pin1 <= 1'b1;
    cyc(6);
    op(0, off_a_snapshot, v1);
    op(0, off_a_snapshot_inv, ~v1);
    op(1, off_a_value, v2);
    op(1, off_a_control, 8'hB3);
    op(0, off_a_value, v1);
    port1_pin0 <= 1'b1;
    cyc(6);
    op(0, off_a_value, v1);
    port1_pin0 <= 1'b0;
    cyc(6);
    op(0, off_a_value, v1 - 8'h01);
    op(1, off_a_control, 8'h00);
    op(1, off_a_control, 8'h8B);
    infrared_input <= 1'b0;
    cyc(6);
    op(0, off_a_snapshot, v2);
    op(0, off_a_snapshot_inv, ~v2);
    port1_pin0 <= 1'b1;
    infrared_input_mode <= 1'b0;
    cyc(6);
    infrared_input <= 1'b1;
    cyc(6);
    infrared_input <= 1'b0;
    cyc(6);
    op(0, off_a_snapshot, v2);
    op(0, off_a_value, v2 - 8'h01);
    cyc(2);
    $display("test capture done");
    wrap_up;
  end
endmodule
`default_nettype wire
